// File: src/tws_pkg.sv
// Shared constants and types for the two-wire register port.
// Assumes both ends import it whole.
package tws_pkg;
  // ==========================================
  // Slave addresses (seven-bit form)
  localparam logic [6:0]  ADDR_PIN_LO = 7'h48;  // Byte 0x90 / 0x91
  localparam logic [6:0]  ADDR_PIN_HI = 7'h5D;  // Byte 0xBA / 0xBB
  // ==========================================
  // Register file
  localparam int          RF_DEPTH    = 8;
  localparam int          RF_IW       = 3;
  localparam logic [2:0]  CFG_IDX     = 3'h0;   // Address override register
  localparam int          CFG_EN_BIT  = 15;     // Override enable bit
  localparam logic [15:0] RF_RST      = 16'h0000;
  // ==========================================
  // Byte roles in a write stream
  localparam logic [1:0]  BI_DEV      = 2'h0;
  localparam logic [1:0]  BI_AHI      = 2'h1;
  localparam logic [1:0]  BI_ALO      = 2'h2;
  localparam logic [1:0]  BI_DAT      = 2'h3;
  // ==========================================
  // Bit timing
  localparam logic [3:0]  BIT_LAST    = 4'h8;   // Eight data bits, then the ack slot
  localparam logic [1:0]  DIV_LAST    = 2'h3;   // Four clocks per quarter bit
  localparam logic [1:0]  QTR_LAST    = 2'h3;
  // ==========================================
  // State types
  typedef enum logic [4:0] {
    D_IDLE = 5'h01,
    D_RX   = 5'h02,
    D_ACK  = 5'h04,
    D_TX   = 5'h08,
    D_RACK = 5'h10
  } tws_dst_t;
  typedef enum logic [3:0] {
    H_IDLE  = 4'h1,
    H_START = 4'h2,
    H_BYTE  = 4'h4,
    H_STOP  = 4'h8
  } tws_hst_t;
  typedef enum logic [7:0] {
    S_DEVW = 8'h01,
    S_AHI  = 8'h02,
    S_ALO  = 8'h04,
    S_DHI  = 8'h08,
    S_DLO  = 8'h10,
    S_DEVR = 8'h20,
    S_RHI  = 8'h40,
    S_RLO  = 8'h80
  } tws_seg_t;
endpackage

// File: src/tws_if.sv
// Two-wire link between master and register slave.
// Assumes open-drain data: an enabled driver pulls low.
`timescale 1ns/10ps
`default_nettype none
interface tws_if;
  logic scl;       // Clock, master only
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic sda;
  // ==========================================
  // Wired-AND level of the data line
  assign sda = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));
  modport master (output scl, output m_sda_o, output m_sda_oe, input sda);
  modport slave (input scl, input sda, output s_sda_o, output s_sda_oe);
endinterface
`default_nettype wire

// File: src/tws_device.sv
// Slave end of the two-wire register port with its register file.
// Assumes LINK_CLK oversamples the bus several times per bit.
`timescale 1ns/10ps
`default_nettype none
module tws_device
  import tws_pkg::*;
(
  // System clock domain
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        CE,
  // Link clock domain
  input  wire logic        LINK_CLK,
  tws_if.slave             BUS,
  input  wire logic        ADDRESS_SELECT_PIN,
  // Write notices and bus busy flag in the system domain
  output logic             WR_STB,
  output logic [15:0]      WR_ADDR,
  output logic [15:0]      WR_DATA,
  output logic             BUS_BUSY
);
  // ==========================================
  // Declarations
  tws_dst_t    st_r;
  logic        scl_m, scl_s, scl_d;
  logic        sda_m, sda_s, sda_d;
  logic        sel_m, sel_s;
  logic        ce_m, ce_s;
  logic        start_c, stop_c, rise, fall;
  logic [3:0]  cnt_r;
  logic [7:0]  sh_r;
  logic        oe_r;
  logic        zero_r;
  logic        rd_r;
  logic        mack_r;
  logic [1:0]  bi_r;
  logic        hl_r, hl_nxt;
  logic [15:0] ptr_r, ptr_nxt;
  logic [7:0]  wbuf_r;
  logic        rx_done;
  logic        adr_hit;
  logic        wr_en;
  logic [6:0]  act_addr;
  logic [7:0]  rd_byte;
  logic [15:0] rf [RF_DEPTH];
  logic        wtog_r;
  logic [15:0] wa_r, wd_r;
  logic        busy_r;
  logic        wt_m, wt_s, wt_d;
  logic        bsy_m;

  // ==========================================
  // Link input synchronisers
  always_ff @(posedge LINK_CLK or negedge RST_N) begin
    if (!RST_N) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sel_m <= 1'b0;
      sel_s <= 1'b0;
      ce_m  <= 1'b0;
      ce_s  <= 1'b0;
    end else begin
      scl_m <= BUS.scl;
      scl_s <= scl_m;
      sda_m <= BUS.sda;
      sda_s <= sda_m;
      sel_m <= ADDRESS_SELECT_PIN;
      sel_s <= sel_m;
      ce_m  <= CE;
      ce_s  <= ce_m;
    end
  end

  // Previous line levels for edge detection
  always_ff @(posedge LINK_CLK or negedge RST_N) begin
    if (!RST_N) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else if (ce_s) begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // ==========================================
  // Bus events
  assign start_c = ce_s & scl_s & scl_d & sda_d & ~sda_s;
  assign stop_c  = ce_s & scl_s & scl_d & ~sda_d & sda_s;
  assign rise    = ce_s & scl_s & ~scl_d;
  assign fall    = ce_s & ~scl_s & scl_d;
  assign rx_done = (st_r == D_RX) & fall & (cnt_r == BIT_LAST);

  // Active address: override register or pin choice
  assign act_addr = rf[CFG_IDX][CFG_EN_BIT] ? rf[CFG_IDX][6:0]
                  : (sel_s ? ADDR_PIN_HI : ADDR_PIN_LO);
  assign adr_hit  = (sh_r[7:1] == act_addr);
  assign wr_en    = rx_done & (bi_r == BI_DAT) & hl_r;
  assign rd_byte  = hl_nxt ? rf[ptr_nxt[RF_IW-1:0]][7:0]
                           : rf[ptr_nxt[RF_IW-1:0]][15:8];

  // ==========================================
  // Byte engine
  always_ff @(posedge LINK_CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_r   <= D_IDLE;
      cnt_r  <= 4'h0;
      sh_r   <= 8'h00;
      oe_r   <= 1'b0;
      rd_r   <= 1'b0;
      mack_r <= 1'b0;
    end else if (start_c) begin
      st_r  <= D_RX;
      cnt_r <= 4'h0;
      oe_r  <= 1'b0;
    end else if (stop_c) begin
      st_r <= D_IDLE;
      oe_r <= 1'b0;
    end else begin
      case (st_r)
        D_RX: begin
          if (rise) begin
            sh_r  <= {sh_r[6:0], sda_s};
            cnt_r <= cnt_r + 4'h1;
          end else if (rx_done) begin
            if (bi_r == BI_DEV) begin
              rd_r <= sh_r[0];
            end
            if ((bi_r != BI_DEV) || adr_hit) begin
              oe_r <= 1'b1;
              st_r <= D_ACK;
            end else begin
              st_r <= D_IDLE;
            end
          end
        end
        D_ACK: begin
          if (fall && rd_r) begin
            oe_r  <= ~rd_byte[7];
            sh_r  <= {rd_byte[6:0], 1'b0};
            cnt_r <= 4'h1;
            st_r  <= D_TX;
          end else if (fall) begin
            oe_r  <= 1'b0;
            cnt_r <= 4'h0;
            st_r  <= D_RX;
          end
        end
        D_TX: begin
          if (fall && (cnt_r == BIT_LAST)) begin
            oe_r <= 1'b0;
            st_r <= D_RACK;
          end else if (fall) begin
            oe_r  <= ~sh_r[7];
            sh_r  <= {sh_r[6:0], 1'b0};
            cnt_r <= cnt_r + 4'h1;
          end
        end
        D_RACK: begin
          if (rise) begin
            mack_r <= ~sda_s;
          end else if (fall && mack_r) begin
            oe_r  <= ~rd_byte[7];
            sh_r  <= {rd_byte[6:0], 1'b0};
            cnt_r <= 4'h1;
            st_r  <= D_TX;
          end else if (fall) begin
            st_r <= D_IDLE;
          end
        end
        default: begin
          st_r <= D_IDLE;
        end
      endcase
    end
  end

  // Byte role within the current transfer
  always_ff @(posedge LINK_CLK or negedge RST_N) begin
    if (!RST_N) begin
      bi_r <= BI_DEV;
    end else if (start_c) begin
      bi_r <= BI_DEV;
    end else if (rx_done && (bi_r != BI_DAT)) begin
      bi_r <= bi_r + 2'h1;
    end
  end

  // ==========================================
  // Register pointer and byte half
  always_comb begin
    ptr_nxt = ptr_r;
    hl_nxt  = hl_r;
    if (rx_done && (bi_r == BI_DEV) && adr_hit) begin
      hl_nxt = 1'b0;
    end else if (rx_done && (bi_r == BI_AHI)) begin
      ptr_nxt = {sh_r, ptr_r[7:0]};
    end else if (rx_done && (bi_r == BI_ALO)) begin
      ptr_nxt = {ptr_r[15:8], sh_r};
    end else if (rx_done && (bi_r == BI_DAT)) begin
      hl_nxt  = ~hl_r;
      ptr_nxt = hl_r ? ptr_r + 16'h0001 : ptr_r;
    end else if ((st_r == D_RACK) && fall && !start_c && !stop_c) begin
      hl_nxt  = ~hl_r;
      ptr_nxt = hl_r ? ptr_r + 16'h0001 : ptr_r;
    end
  end

  always_ff @(posedge LINK_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ptr_r  <= 16'h0000;
      hl_r   <= 1'b0;
      wbuf_r <= 8'h00;
    end else begin
      ptr_r <= ptr_nxt;
      hl_r  <= hl_nxt;
      if (rx_done && (bi_r == BI_DAT) && !hl_r) begin
        wbuf_r <= sh_r;
      end
    end
  end

  // ==========================================
  // Register file, one word per entry
  for (genvar gi = 0; gi < RF_DEPTH; gi++) begin : g_rf
    always_ff @(posedge LINK_CLK or negedge RST_N) begin
      if (!RST_N) begin
        rf[gi] <= RF_RST;
      end else if (wr_en && (ptr_r[RF_IW-1:0] == RF_IW'(gi))) begin
        rf[gi] <= {wbuf_r, sh_r};
      end
    end
  end

  // Write notice held for the system domain
  always_ff @(posedge LINK_CLK or negedge RST_N) begin
    if (!RST_N) begin
      wtog_r <= 1'b0;
      wa_r   <= 16'h0000;
      wd_r   <= 16'h0000;
      busy_r <= 1'b0;
    end else begin
      if (ce_s) begin
        busy_r <= (st_r != D_IDLE);
      end
      if (wr_en) begin
        wtog_r <= ~wtog_r;
        wa_r   <= ptr_r;
        wd_r   <= {wbuf_r, sh_r};
      end
    end
  end

  // Open-drain drive: low while enabled
  always_ff @(posedge LINK_CLK or negedge RST_N) begin
    if (!RST_N) begin
      zero_r <= 1'b0;
    end else begin
      zero_r <= 1'b0;
    end
  end
  assign BUS.s_sda_oe = oe_r;
  assign BUS.s_sda_o  = zero_r;

  // ==========================================
  // System domain: toggle and level crossings
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      wt_m     <= 1'b0;
      wt_s     <= 1'b0;
      bsy_m    <= 1'b0;
      BUS_BUSY <= 1'b0;
    end else if (CE) begin
      wt_m     <= wtog_r;
      wt_s     <= wt_m;
      bsy_m    <= busy_r;
      BUS_BUSY <= bsy_m;
    end
  end

  // One strobe per completed register write
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      wt_d    <= 1'b0;
      WR_STB  <= 1'b0;
      WR_ADDR <= 16'h0000;
      WR_DATA <= 16'h0000;
    end else if (CE) begin
      wt_d   <= wt_s;
      WR_STB <= (wt_s != wt_d);
      if (wt_s != wt_d) begin
        WR_ADDR <= wa_r;
        WR_DATA <= wd_r;
      end
    end
  end
endmodule
`default_nettype wire

// File: src/tws_host.sv
// Master end of the two-wire register port.
// Assumes the slave answers within a quarter bit of the clock falling.
`timescale 1ns/10ps
`default_nettype none
module tws_host
  import tws_pkg::*;
(
  // System
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        CE,
  // Link
  tws_if.master            BUS,
  // Command
  input  wire logic        CMD_VALID,
  input  wire logic        CMD_READ,
  input  wire logic        CMD_CURRENT,
  input  wire logic [15:0] CMD_ADDR,
  input  wire logic [15:0] CMD_DATA,
  input  wire logic [3:0]  CMD_WORDS,
  input  wire logic [6:0]  SLAVE_ADDR,
  // Answer
  output logic             CMD_READY,
  output logic             DATA_NEXT,
  output logic             RD_VALID,
  output logic [15:0]      RD_DATA,
  output logic             NACK_ERR
);
  // ==========================================
  // Declarations
  tws_hst_t    st_r;
  tws_seg_t    seg_r;
  logic [1:0]  div_r, qtr_r;
  logic [3:0]  bit_r, wl_r;
  logic [8:0]  tx_r;
  logic [7:0]  rx_r, rdh_r;
  logic [8:0]  rxn;
  logic [15:0] adr_r, dat_r;
  logic [6:0]  sa_r;
  logic        rd_r, cur_r, rst_r;
  logic        scl_r, oe_r, zero_r;
  logic        sda_m, sda_s;
  logic        tick, sym_end, last_w;

  assign tick    = (div_r == DIV_LAST);
  assign sym_end = tick & (qtr_r == QTR_LAST);
  assign rxn     = {rx_r, sda_s};
  assign last_w  = (wl_r == 4'h1);

  // ==========================================
  // Data line synchroniser and constant low drive
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sda_m  <= 1'b1;
      sda_s  <= 1'b1;
      zero_r <= 1'b0;
    end else begin
      sda_m  <= BUS.sda;
      sda_s  <= sda_m;
      zero_r <= 1'b0;
    end
  end

  // Quarter-bit timing
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      div_r <= 2'h0;
      qtr_r <= 2'h0;
    end else if (CE && (st_r == H_IDLE)) begin
      div_r <= 2'h0;
      qtr_r <= 2'h0;
    end else if (CE) begin
      div_r <= div_r + 2'h1;
      qtr_r <= tick ? qtr_r + 2'h1 : qtr_r;
    end
  end

  // ==========================================
  // Symbol and sequence engine
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_r <= H_IDLE;
      seg_r <= S_DEVW;
      bit_r <= 4'h0;
      wl_r <= 4'h0;
      tx_r <= 9'h1FF;
      rx_r <= 8'h00;
      rdh_r <= 8'h00;
      adr_r <= 16'h0000;
      dat_r <= 16'h0000;
      sa_r <= 7'h00;
      rd_r <= 1'b0;
      cur_r <= 1'b0;
      rst_r <= 1'b0;
      scl_r <= 1'b1;
      oe_r <= 1'b0;
      CMD_READY <= 1'b1;
      DATA_NEXT <= 1'b0;
      RD_VALID <= 1'b0;
      RD_DATA <= 16'h0000;
      NACK_ERR <= 1'b0;
    end else if (CE) begin
      DATA_NEXT <= 1'b0;
      RD_VALID  <= 1'b0;
      case (st_r)
        H_IDLE: begin
          if (CMD_VALID) begin
            st_r <= H_START;
            scl_r <= 1'b0;
            adr_r <= CMD_ADDR;
            dat_r <= CMD_DATA;
            DATA_NEXT <= ~CMD_READ;
            sa_r <= SLAVE_ADDR;
            rd_r <= CMD_READ;
            cur_r <= CMD_READ & CMD_CURRENT;
            rst_r <= 1'b0;
            wl_r <= (CMD_WORDS == 4'h0) ? 4'h1 : CMD_WORDS;
            CMD_READY <= 1'b0;
            NACK_ERR <= 1'b0;
          end
        end
        H_START: begin
          if (tick && (qtr_r == 2'h0)) begin
            oe_r <= 1'b0;
          end else if (tick && (qtr_r == 2'h1)) begin
            scl_r <= 1'b1;
          end else if (tick && (qtr_r == 2'h2)) begin
            oe_r <= 1'b1;
          end else if (sym_end) begin
            scl_r <= 1'b0;
            st_r <= H_BYTE;
            bit_r <= 4'h0;
            seg_r <= (rst_r || cur_r) ? S_DEVR : S_DEVW;
            tx_r <= {sa_r, rst_r | cur_r, 1'b1};
          end
        end
        H_STOP: begin
          if (tick && (qtr_r == 2'h0)) begin
            oe_r <= 1'b1;
          end else if (tick && (qtr_r == 2'h1)) begin
            scl_r <= 1'b1;
          end else if (tick && (qtr_r == 2'h2)) begin
            oe_r <= 1'b0;
          end else if (sym_end) begin
            st_r <= H_IDLE;
            CMD_READY <= 1'b1;
          end
        end
        H_BYTE: begin
          if (tick && (qtr_r == 2'h0)) begin
            oe_r <= ~tx_r[8];
          end else if (tick && (qtr_r == 2'h1)) begin
            scl_r <= 1'b1;
          end else if (sym_end && (bit_r != BIT_LAST)) begin
            scl_r <= 1'b0;
            rx_r <= rxn[7:0];
            tx_r <= {tx_r[7:0], 1'b1};
            bit_r <= bit_r + 4'h1;
          end else if (sym_end) begin
            scl_r <= 1'b0;
            bit_r <= 4'h0;
            if (rxn[0] && (seg_r != S_RHI) && (seg_r != S_RLO)) begin
              st_r <= H_STOP;
              NACK_ERR <= 1'b1;
            end else begin
              case (seg_r)
                S_DEVW: begin
                  seg_r <= S_AHI;
                  tx_r <= {adr_r[15:8], 1'b1};
                end
                S_AHI: begin
                  seg_r <= S_ALO;
                  tx_r <= {adr_r[7:0], 1'b1};
                end
                S_ALO: begin
                  if (rd_r) begin
                    st_r <= H_START;
                    rst_r <= 1'b1;
                  end else begin
                    seg_r <= S_DHI;
                    tx_r <= {dat_r[15:8], 1'b1};
                  end
                end
                S_DHI: begin
                  seg_r <= S_DLO;
                  tx_r <= {dat_r[7:0], 1'b1};
                end
                S_DLO: begin
                  if (last_w) begin
                    st_r <= H_STOP;
                  end else begin
                    wl_r <= wl_r - 4'h1;
                    seg_r <= S_DHI;
                    dat_r <= CMD_DATA;
                    DATA_NEXT <= 1'b1;
                    tx_r <= {CMD_DATA[15:8], 1'b1};
                  end
                end
                S_DEVR: begin
                  seg_r <= S_RHI;
                  tx_r <= 9'h1FE;
                end
                S_RHI: begin
                  rdh_r <= rxn[8:1];
                  seg_r <= S_RLO;
                  tx_r <= {8'hFF, last_w};
                end
                default: begin
                  RD_DATA <= {rdh_r, rxn[8:1]};
                  RD_VALID <= 1'b1;
                  if (last_w) begin
                    st_r <= H_STOP;
                  end else begin
                    wl_r <= wl_r - 4'h1;
                    seg_r <= S_RHI;
                    tx_r <= 9'h1FE;
                  end
                end
              endcase
            end
          end
        end
        default: begin
          st_r <= H_IDLE;
        end
      endcase
    end
  end

  assign BUS.scl      = scl_r;
  assign BUS.m_sda_oe = oe_r;
  assign BUS.m_sda_o  = zero_r;
endmodule
`default_nettype wire

// File: bench/tws_assertions.sv
// Protocol checks on the two-wire link between host and register slave.
// Assumes it sits beside the link interface, fed with its plain signals.
`timescale 1ns/10ps
`default_nettype none
module tws_assertions (
  // Clocks and reset
  input wire logic CLK,
  input wire logic LINK_CLK,
  input wire logic RST_N,
  // Link signals
  input wire logic scl,
  input wire logic sda,
  input wire logic m_sda_oe,
  input wire logic s_sda_oe
);
  // ==========================================
  // Bus timing and line ownership, two clock domains so each check names its clock

  // Each clock phase lasts a full half bit
  scl_high_span_a: assert property (@(posedge CLK) disable iff (!RST_N)
    $rose(scl) |-> scl [*8])
    else $error("Clock high phase too short");
  scl_low_span_a: assert property (@(posedge CLK) disable iff (!RST_N)
    $fell(scl) |-> !scl [*8])
    else $error("Clock low phase too short");
  // Slave output steady while the clock is high
  dev_hold_a: assert property (@(posedge CLK) disable iff (!RST_N)
    scl && $past(scl) |-> $stable(s_sda_oe))
    else $error("Slave changed data while clock high");
  // Only one party drives while the clock is high
  one_driver_a: assert property (@(posedge CLK) disable iff (!RST_N)
    scl && s_sda_oe |-> !m_sda_oe)
    else $error("Both ends drive data while clock high");
  // Start condition comes from the host
  start_by_host_a: assert property (@(posedge CLK) disable iff (!RST_N)
    $fell(sda) && scl && $past(scl) |-> m_sda_oe)
    else $error("Start not made by host");
  // A stop leaves both lines high
  stop_idle_a: assert property (@(posedge CLK) disable iff (!RST_N)
    $rose(sda) && scl && $past(scl) |=> (scl && sda) [*2])
    else $error("Bus not idle after stop");
  // Slave drives only early in a low phase
  ack_drive_a: assert property (@(posedge CLK) disable iff (!RST_N)
    $rose(s_sda_oe) |-> !scl [*3])
    else $error("Slave drive started too late");
  // Same hold rule seen from the link clock
  link_hold_a: assert property (@(posedge LINK_CLK) disable iff (!RST_N) !$stable(s_sda_oe) |-> !scl)
    else $error("Slave output moved with clock high");
endmodule
`default_nettype wire

// File: bench/two_wire_register_slave_tb_top.sv
// Testbench joining host and register slave over the two-wire link.
// Assumes the package, interface, both ends and the checker compile first.
`timescale 1ns/10ps
`default_nettype none
module two_wire_register_slave_tb_top
  import tws_pkg::*;
;
  logic        clk;
  logic        link_clk;
  logic        rst_n;
  logic        ce;
  logic        addr_sel;
  logic        cmd_valid;
  logic        cmd_read;
  logic        cmd_current;
  logic [15:0] cmd_addr;
  logic [15:0] cmd_data;
  logic [3:0]  cmd_words;
  logic [6:0]  slave_addr;
  logic        cmd_ready;
  logic        rd_valid;
  logic [15:0] rd_data;
  logic        nack_err;
  logic        wr_stb;
  logic [15:0] wr_addr;
  logic [15:0] wr_data;
  logic        bus_busy;
  logic        data_next;
  logic [15:0] rd_q[$];
  int          wr_cnt;
  int          dn_cnt;
  int          num_errors;
  int          comparisons;
  // ==========================================
  // Link, both ends and checker
  tws_if link_if ();
  tws_device tws_device_i (.CLK(clk), .RST_N(rst_n), .CE(ce), .LINK_CLK(link_clk), .BUS(link_if.slave),
    .ADDRESS_SELECT_PIN(addr_sel), .WR_STB(wr_stb), .WR_ADDR(wr_addr), .WR_DATA(wr_data), .BUS_BUSY(bus_busy));
  tws_host tws_host_i (.CLK(clk), .RST_N(rst_n), .CE(ce), .BUS(link_if.master), .CMD_VALID(cmd_valid),
    .CMD_READ(cmd_read), .CMD_CURRENT(cmd_current), .CMD_ADDR(cmd_addr), .CMD_DATA(cmd_data),
    .CMD_WORDS(cmd_words), .SLAVE_ADDR(slave_addr), .CMD_READY(cmd_ready), .DATA_NEXT(data_next),
    .RD_VALID(rd_valid), .RD_DATA(rd_data), .NACK_ERR(nack_err));
  tws_assertions tws_assertions_i (.CLK(clk), .LINK_CLK(link_clk), .RST_N(rst_n), .scl(link_if.scl),
    .sda(link_if.sda), .m_sda_oe(link_if.m_sda_oe), .s_sda_oe(link_if.s_sda_oe));
  // ==========================================
  // Clocks, unrelated in phase
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  initial begin
    link_clk = 1'h0;
    #7;
    forever #15 link_clk = ~link_clk;
  end
  // Collect read words and count write notices
  always @(posedge clk) begin
    if (rd_valid === 1'h1) rd_q.push_back(rd_data);
    if (wr_stb === 1'h1) wr_cnt++;
    if (data_next === 1'h1) dn_cnt++;
  end
  // ==========================================
  // Tasks
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One host command, held for one clock, then wait for idle
  task automatic run_cmd(input logic rd, input logic cur, input logic [15:0] a, input logic [15:0] d,
                         input logic [3:0] n);
    int i;
    rd_q.delete();
    @(negedge clk);
    cmd_read = rd;
    cmd_current = cur;
    cmd_addr = a;
    cmd_data = d;
    cmd_words = n;
    cmd_valid = 1'h1;
    @(negedge clk);
    cmd_valid = 1'h0;
    i = 0;
    while (cmd_ready !== 1'h1 && i < 5000) begin
      @(negedge clk);
      i++;
    end
    chk("cmd_done", 16'h0001, {15'h0000, cmd_ready});
  endtask
  task automatic complete_run();
    if (num_errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ==========================================
  // Watchdog
  initial begin
    #2000000;
    num_errors++;
    complete_run();
  end
  // ==========================================
  // Scenarios
  initial begin
    rst_n = 1'h0;
    ce = 1'h1;
    addr_sel = 1'h0;
    cmd_valid = 1'h0;
    cmd_read = 1'h0;
    cmd_current = 1'h0;
    cmd_addr = 16'h0000;
    cmd_data = 16'h0000;
    cmd_words = 4'h1;
    slave_addr = ADDR_PIN_LO;
    wr_cnt = 0;
    dn_cnt = 0;
    num_errors = 0;
    comparisons = 0;
    repeat (2) @(negedge clk);
    rst_n = 1'h1;
    repeat (4) @(negedge clk);
    chk("idle_lines", 16'h0003, {14'h0000, link_if.scl, link_if.sda});
    run_cmd(1'h0, 1'h0, 16'h0003, 16'hA5C3, 4'h1);
    chk("wr_addr", 16'h0003, wr_addr);
    chk("wr_data", 16'hA5C3, wr_data);
    chk("nack_lo", 16'h0000, {15'h0000, nack_err});
    // Clock enable dropped in mid-transfer only stretches the transfer
    fork
      run_cmd(1'h0, 1'h0, 16'h0004, 16'h5A3C, 4'h1);
      begin
        repeat (200) @(negedge clk);
        chk("busy_mid", 16'h0001, {15'h0000, bus_busy});
        ce = 1'h0;
        repeat (20) @(negedge clk);
        ce = 1'h1;
      end
    join
    chk("wr_data_ce", 16'h5A3C, wr_data);
    chk("wr_count", 16'h0002, wr_cnt[15:0]);
    // Random read of two words across a repeated start
    run_cmd(1'h1, 1'h0, 16'h0003, 16'h0000, 4'h2);
    chk("rd_word0", 16'hA5C3, rd_q[0]);
    chk("rd_word1", 16'h5A3C, rd_q[1]);
    // Pointer left by a write serves a current read
    run_cmd(1'h0, 1'h0, 16'h0002, 16'h1234, 4'h1);
    run_cmd(1'h1, 1'h1, 16'h0000, 16'h0000, 4'h1);
    chk("rd_current", 16'hA5C3, rd_q[0]);
    run_cmd(1'h0, 1'h0, 16'h0005, 16'hC0DE, 4'h2);
    chk("seq_wr_addr", 16'h0006, wr_addr);
    chk("seq_wr_data", 16'hC0DE, wr_data);
    chk("seq_wr_count", 16'h0005, wr_cnt[15:0]);
    chk("data_next_cnt", 16'h0005, dn_cnt[15:0]);
    // Other address while the select pin is low is refused
    slave_addr = ADDR_PIN_HI;
    run_cmd(1'h0, 1'h0, 16'h0007, 16'h7777, 4'h1);
    chk("nack_wrong", 16'h0001, {15'h0000, nack_err});
    chk("wr_refused", 16'h0005, wr_cnt[15:0]);
    addr_sel = 1'h1;
    repeat (4) @(negedge clk);
    chk("busy_idle", 16'h0000, {15'h0000, bus_busy});
    run_cmd(1'h0, 1'h0, 16'h0007, 16'h7777, 4'h1);
    chk("nack_sel", 16'h0000, {15'h0000, nack_err});
    chk("wr_sel", 16'h0006, wr_cnt[15:0]);
    // Address override through register 0, a word count of zero meaning one
    run_cmd(1'h0, 1'h0, 16'h0000, 16'h8033, 4'h0);
    chk("wr_cfg_count", 16'h0007, wr_cnt[15:0]);
    slave_addr = 7'h33;
    run_cmd(1'h1, 1'h0, 16'h0007, 16'h0000, 4'h1);
    chk("nack_cfg", 16'h0000, {15'h0000, nack_err});
    chk("rd_cfg", 16'h7777, rd_q[0]);
    complete_run();
  end
endmodule
`default_nettype wire
